// *** common/fblm_pkg.sv ***
package fblm_pkg;
  // slave population and addressing
  localparam int MAX_SLAVES = 15;
  localparam int ADDR_W = 4;
  localparam logic [3:0] MASTER_ADDR = 4'h0;
  localparam int TYPE_W = 8;
  localparam int DATA_W = 16;
  // error total counter
  localparam int ERR_W = 16;
  localparam logic [15:0] ERR_MAX = 16'hFFFF;
  localparam logic [15:0] ERR_RESET = 16'h0000;
  // retry setting
  localparam int RETRY_W = 2;
  localparam logic [1:0] RETRY_RESET = 2'h0;
  // host commands
  typedef enum logic [2:0] {
    FBLM_CMD_READ_TYPE = 3'b000,
    FBLM_CMD_READ_ERR = 3'b001,
    FBLM_CMD_CLEAR_ERR = 3'b010,
    FBLM_CMD_ENV_SET = 3'b011,
    FBLM_CMD_WRITE_INIT = 3'b100,
    FBLM_CMD_SEND_INIT = 3'b101,
    FBLM_CMD_TRANSFER = 3'b110
  } fblm_cmd_t;
  // host answer status codes
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_BUSY = 2'h1;
  localparam logic [1:0] ST_INIT_ERR = 2'h2;
  localparam logic [1:0] ST_BUS_ERR = 2'h3;
  // bus request kinds
  localparam logic [1:0] REQ_INIT = 2'h0;
  localparam logic [1:0] REQ_INIT_DATA = 2'h1;
  localparam logic [1:0] REQ_USER = 2'h2;
  // slave reply status codes
  localparam logic [1:0] RSP_OK = 2'h0;
  localparam logic [1:0] RSP_INIT_ERR = 2'h1;
  localparam logic [1:0] RSP_FAIL = 2'h2;
endpackage

// *** dv/fblm_checker.sv ***
module fblm_checker (
  // watched ports
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_from_tool_in,
  input wire fblm_pkg::fblm_cmd_t cmd_code_in,
  input wire logic cmd_ready_out,
  input wire logic rsp_valid_out,
  input wire logic [1:0] rsp_status_out,
  input wire logic bus_req_valid_out,
  input wire logic [1:0] bus_req_kind_out,
  input wire logic [3:0] bus_req_src_out,
  input wire logic [3:0] bus_req_dst_out,
  input wire logic bus_rsp_valid_in,
  input wire logic hw_fault_in,
  input wire logic error_indicator_out,
  input wire logic host_ready_indicator_out,
  input wire logic tool_has_ctrl_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  logic take, right, clr_take;
  // accepted command and port ownership
  assign take = cmd_valid_in && cmd_ready_out;
  assign right = cmd_from_tool_in == tool_has_ctrl_out;
  assign clr_take = take && right && cmd_code_in == fblm_pkg::FBLM_CMD_CLEAR_ERR;
  sequence s_env_take;
    take && right && cmd_code_in == fblm_pkg::FBLM_CMD_ENV_SET;
  endsequence
  sequence s_first_init;
    bus_req_valid_out && bus_req_dst_out == 4'h1 && bus_req_kind_out == fblm_pkg::REQ_INIT;
  endsequence
  chk_sweep_start: assert property (s_env_take |-> ##[1:3] s_first_init)
    else $error("sweep did not open at slave 1");
  chk_src_zero: assert property (bus_req_valid_out |-> bus_req_src_out == 4'h0)
    else $error("master address not zero");
  chk_ready_led: assert property (host_ready_indicator_out == !tool_has_ctrl_out)
    else $error("ready indicator wrong");
  chk_wrong_port: assert property (take && !right |=> rsp_valid_out
    && rsp_status_out == fblm_pkg::ST_BUSY)
    else $error("wrong port not answered busy");
  chk_fault_led: assert property (hw_fault_in |-> ##[1:4] error_indicator_out)
    else $error("fault did not light indicator");
  chk_led_sticky: assert property ($fell(error_indicator_out)
    |-> $past(clr_take) || $past(clr_take, 2))
    else $error("error indicator dropped");
  // request may only fall in the cycle its reply shows
  chk_req_hold: assert property (bus_req_valid_out && !bus_rsp_valid_in
    |=> (bus_req_valid_out || bus_rsp_valid_in) && $stable(bus_req_dst_out))
    else $error("request dropped before reply");
  chk_ctrl_idle: assert property ($changed(tool_has_ctrl_out)
    |-> $past(cmd_ready_out && !cmd_valid_in))
    else $error("control moved while busy");
endmodule

bind fblm_link_manager fblm_checker u_chk (.clock_in, .arst_n_in, .cmd_valid_in,
  .cmd_from_tool_in, .cmd_code_in, .cmd_ready_out, .rsp_valid_out, .rsp_status_out,
  .bus_req_valid_out, .bus_req_kind_out, .bus_req_src_out, .bus_req_dst_out,
  .bus_rsp_valid_in, .hw_fault_in, .error_indicator_out, .host_ready_indicator_out,
  .tool_has_ctrl_out);

// *** dv/fblm_slave_model.sv ***
module fblm_slave_model (
  // clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // request and test controls
  input wire logic req_valid_in,
  input wire logic [1:0] req_kind_in,
  input wire logic [3:0] req_dst_in,
  input wire logic [15:0] req_data_in,
  input wire logic [3:0] fail_in,
  input wire logic [3:0] delay_in,
  // reply
  output logic rsp_valid_out,
  output logic [1:0] rsp_status_out,
  output logic [7:0] rsp_type_out,
  output logic [15:0] rsp_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] up_reg;
  logic [15:0] init_data [16];
  logic [3:0] wait_reg, fails_reg;
  int n_init;
  // one reply per request after delay_in cycles; idle lines toggle
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      up_reg <= 16'h0000;
      {wait_reg, fails_reg, rsp_status_out} <= 10'h000;
      {rsp_valid_out, rsp_type_out, rsp_data_out} <= 25'h0A5A5A5;
      n_init <= 0;
    end else begin
      rsp_valid_out <= 1'b0;
      rsp_type_out <= ~rsp_type_out;
      rsp_data_out <= ~rsp_data_out;
      if (!req_valid_in) fails_reg <= 4'h0;
      if (req_valid_in && !rsp_valid_out && wait_reg < delay_in) wait_reg <= wait_reg + 4'h1;
      else if (req_valid_in && !rsp_valid_out) begin
        wait_reg <= 4'h0;
        rsp_valid_out <= 1'b1;
        rsp_type_out <= 8'h10 + 8'(req_dst_in);
        rsp_data_out <= req_data_in;
        rsp_status_out <= fblm_pkg::RSP_OK;
        if (fails_reg < fail_in) begin
          fails_reg <= fails_reg + 4'h1;
          rsp_status_out <= fblm_pkg::RSP_FAIL;
        end else if (req_kind_in == fblm_pkg::REQ_INIT) begin
          up_reg[req_dst_in] <= 1'b1;
          n_init <= n_init + 1;
        end else if (!up_reg[req_dst_in]) rsp_status_out <= fblm_pkg::RSP_INIT_ERR;
        else if (req_kind_in == fblm_pkg::REQ_INIT_DATA) init_data[req_dst_in] <= req_data_in;
      end
    end
  end
endmodule

// *** dv/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0, arst_n_in = 1'b0, tool_ctrl_req_in = 1'b0, cmd_valid_in = 1'b0;
  logic cmd_from_tool_in = 1'b0, bus_err_in = 1'b0, hw_fault_in = 1'b0;
  fblm_pkg::fblm_cmd_t cmd_code_in = fblm_pkg::FBLM_CMD_READ_ERR;
  logic [3:0] cmd_addr_in = 4'h0, fail_n = 4'h0, dly = 4'h0, bus_req_src_out, bus_req_dst_out;
  logic [15:0] cmd_data_in = 16'h0000, rdat, rsp_data_out, bus_req_data_out, bus_rsp_data_in;
  logic [1:0] rst, rsp_status_out, bus_req_kind_out, bus_rsp_status_in;
  logic cmd_ready_out, rsp_valid_out, bus_req_valid_out, bus_rsp_valid_in;
  logic error_indicator_out, host_ready_indicator_out, tool_has_ctrl_out;
  logic [7:0] bus_rsp_type_in;
  int n_errors = 0, n_compared = 0;
  always #20 clock_in = ~clock_in;
  fblm_link_manager uut (.clock_in, .arst_n_in, .tool_ctrl_req_in, .cmd_valid_in,
    .cmd_from_tool_in, .cmd_code_in, .cmd_addr_in, .cmd_data_in, .cmd_ready_out,
    .rsp_valid_out, .rsp_status_out, .rsp_data_out, .bus_req_valid_out, .bus_req_kind_out,
    .bus_req_src_out, .bus_req_dst_out, .bus_req_data_out, .bus_rsp_valid_in,
    .bus_rsp_status_in, .bus_rsp_type_in, .bus_rsp_data_in, .bus_err_in, .hw_fault_in,
    .error_indicator_out, .host_ready_indicator_out, .tool_has_ctrl_out);
  fblm_slave_model u_slv (.clock_in, .arst_n_in, .req_valid_in(bus_req_valid_out),
    .req_kind_in(bus_req_kind_out), .req_dst_in(bus_req_dst_out),
    .req_data_in(bus_req_data_out), .fail_in(fail_n), .delay_in(dly),
    .rsp_valid_out(bus_rsp_valid_in), .rsp_status_out(bus_rsp_status_in),
    .rsp_type_out(bus_rsp_type_in), .rsp_data_out(bus_rsp_data_in));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one host command: hold until taken, then wait for the answer
  task cmd(input logic t, input fblm_pkg::fblm_cmd_t c, input logic [3:0] a,
    input logic [15:0] d);
    int i;
    @(posedge clock_in);
    #1;
    cmd_valid_in = 1'b1;
    cmd_from_tool_in = t;
    cmd_code_in = c;
    cmd_addr_in = a;
    cmd_data_in = d;
    for (i = 0; i < 50 && cmd_ready_out !== 1'b1; i++) @(posedge clock_in) #1;
    if (cmd_ready_out !== 1'b1) n_errors++;
    @(posedge clock_in);
    #1;
    cmd_valid_in = 1'b0;
    for (i = 0; i < 2000 && rsp_valid_out !== 1'b1; i++) @(posedge clock_in) #1;
    if (rsp_valid_out !== 1'b1) n_errors++;
    rst = rsp_status_out;
    rdat = rsp_data_out;
  endtask
  task automatic pulse(ref logic s, input int n);
    @(posedge clock_in);
    #1;
    s = 1'b1;
    repeat (n) @(posedge clock_in);
    #1;
    s = 1'b0;
  endtask
  task t_reset;
    chk(error_indicator_out, 1'b0);
    chk(host_ready_indicator_out, 1'b1);
    cmd(1'b0, fblm_pkg::FBLM_CMD_READ_ERR, 4'h0, 16'h0000);
    chk(rdat, 16'h0000);
    $display("test reset done");
  endtask
  task t_env;
    cmd(1'b0, fblm_pkg::FBLM_CMD_TRANSFER, 4'h2, 16'h1234);
    chk(rst, fblm_pkg::ST_INIT_ERR);
    dly = 4'h3;
    cmd(1'b0, fblm_pkg::FBLM_CMD_ENV_SET, 4'h0, 16'h0002);
    chk(u_slv.n_init, 15);
    cmd(1'b0, fblm_pkg::FBLM_CMD_READ_TYPE, 4'h3, 16'h0000);
    chk(rdat, 16'h0013);
    $display("test setup done");
  endtask
  task t_retry;
    dly = 4'h0;
    fail_n = 4'h2;
    cmd(1'b0, fblm_pkg::FBLM_CMD_TRANSFER, 4'h4, 16'h5A5A);
    chk(rst, fblm_pkg::ST_OK);
    cmd(1'b0, fblm_pkg::FBLM_CMD_READ_ERR, 4'h0, 16'h0000);
    chk(rdat, 16'h0002);
    fail_n = 4'h3;
    cmd(1'b0, fblm_pkg::FBLM_CMD_TRANSFER, 4'h4, 16'h5A5A);
    chk(rst, fblm_pkg::ST_BUS_ERR);
    fail_n = 4'h0;
    cmd(1'b0, fblm_pkg::FBLM_CMD_CLEAR_ERR, 4'h0, 16'h0000);
    cmd(1'b0, fblm_pkg::FBLM_CMD_READ_ERR, 4'h0, 16'h0000);
    chk(rdat, 16'h0000);
    pulse(bus_err_in, 3);
    cmd(1'b0, fblm_pkg::FBLM_CMD_READ_ERR, 4'h0, 16'h0000);
    chk(rdat, 16'h0003);
    cmd(1'b0, fblm_pkg::FBLM_CMD_ENV_SET, 4'h0, 16'h0000);
    fail_n = 4'h1;
    cmd(1'b0, fblm_pkg::FBLM_CMD_TRANSFER, 4'h4, 16'h5A5A);
    chk(rst, fblm_pkg::ST_BUS_ERR);
    fail_n = 4'h0;
    $display("test retry done");
  endtask
  task t_tool;
    cmd(1'b0, fblm_pkg::FBLM_CMD_CLEAR_ERR, 4'h0, 16'h0000);
    chk(error_indicator_out, 1'b0);
    pulse(hw_fault_in, 1);
    tool_ctrl_req_in = 1'b1;
    repeat (6) @(posedge clock_in);
    #1;
    chk({tool_has_ctrl_out, host_ready_indicator_out}, 2'b10);
    chk(error_indicator_out, 1'b1);
    cmd(1'b0, fblm_pkg::FBLM_CMD_READ_ERR, 4'h0, 16'h0000);
    chk(rst, fblm_pkg::ST_BUSY);
    cmd(1'b1, fblm_pkg::FBLM_CMD_WRITE_INIT, 4'h5, 16'hBEEF);
    chk(rst, fblm_pkg::ST_OK);
    cmd(1'b1, fblm_pkg::FBLM_CMD_SEND_INIT, 4'h0, 16'h0000);
    chk(u_slv.init_data[5], 16'hBEEF);
    tool_ctrl_req_in = 1'b0;
    repeat (6) @(posedge clock_in);
    #1;
    chk(host_ready_indicator_out, 1'b1);
    $display("test tool done");
  endtask
  task t_sat;
    pulse(bus_err_in, 65540);
    cmd(1'b0, fblm_pkg::FBLM_CMD_READ_ERR, 4'h0, 16'h0000);
    chk(rdat, 16'hFFFF);
    $display("test saturate done");
  endtask
  // reset for three cycles, then the scenarios in order
  initial begin
    repeat (3) @(posedge clock_in);
    #1;
    arst_n_in = 1'b1;
    t_reset;
    t_env;
    t_retry;
    t_tool;
    t_sat;
    end_sim;
  end
  // watchdog: about 66k cycles expected, cut off at 100k
  initial begin
    #4000000;
    n_errors++;
    end_sim;
  end
endmodule

// *** verilog/fblm_link_manager.sv ***
// How it works
// (RL1) host reads back the type of each connected slave
// (RL2) each detected bus error and each retry bumps the error total; a bus error and a retry in the same cycle add only one
// (RL3) error total stops at 65535
// (RL4) host clear request sets the error total to zero; a clear in the same cycle as a new error is dropped and the error is counted
// (RL5) retry limit is taken from the environment-setup parameters
// (RL6) failed transfers are resent automatically while retries remain
// (RL7) retry setting spans 0 to 3, zero means no retry
// (RL8) environment-setup sends an initialization request to every slave
// (RL9) slaves refuse all but initialization until initialized
// (RL10) an uninitialized slave answers other requests with initialization error
// (RL11) a slave initialization error is passed back to the host
// (RL12) host repeats environment-setup after a slave powers on
// (RL13) per-slave initial data written from the support-tool port is kept
// (RL14) initial-data request sends stored data to each slave separately
// (RL15) commands accepted from both host ports
// (RL16) only one port holds control; tool port takes it when user idle
// (RL17) error indicator lights on abnormality and stays lit on tool control
// (RL18) ready indicator on while user port has access, off on tool control
// (RL19) master address fixed at zero
// (RL20) error total starts from zero at power-up
// (RL21) commands from the port without control answer busy
module fblm_link_manager #(
  parameter int NSLV = fblm_pkg::MAX_SLAVES
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // control right request from the support-tool port (pin level)
  input wire logic tool_ctrl_req_in,
  // host command, from either port
  input wire logic cmd_valid_in,
  input wire logic cmd_from_tool_in,
  input wire fblm_pkg::fblm_cmd_t cmd_code_in,
  input wire logic [fblm_pkg::ADDR_W-1:0] cmd_addr_in,
  input wire logic [fblm_pkg::DATA_W-1:0] cmd_data_in,
  output logic cmd_ready_out,
  // host answer
  output logic rsp_valid_out,
  output logic [1:0] rsp_status_out,
  output logic [fblm_pkg::DATA_W-1:0] rsp_data_out,
  // bus request toward the frame engine
  output logic bus_req_valid_out,
  output logic [1:0] bus_req_kind_out,
  output logic [fblm_pkg::ADDR_W-1:0] bus_req_src_out,
  output logic [fblm_pkg::ADDR_W-1:0] bus_req_dst_out,
  output logic [fblm_pkg::DATA_W-1:0] bus_req_data_out,
  // bus reply from the frame engine
  input wire logic bus_rsp_valid_in,
  input wire logic [1:0] bus_rsp_status_in,
  input wire logic [fblm_pkg::TYPE_W-1:0] bus_rsp_type_in,
  input wire logic [fblm_pkg::DATA_W-1:0] bus_rsp_data_in,
  input wire logic bus_err_in,
  input wire logic hw_fault_in,
  // indicators and status
  output logic error_indicator_out,
  output logic host_ready_indicator_out,
  output logic tool_has_ctrl_out
);
  typedef enum logic [2:0] {
    FBLM_IDLE = 3'b000,
    FBLM_SEND = 3'b001,
    FBLM_WAIT = 3'b010,
    FBLM_NEXT = 3'b011,
    FBLM_DONE = 3'b100
  } fblm_state_t;

  localparam logic [fblm_pkg::ADDR_W-1:0] LAST_ADDR = NSLV[fblm_pkg::ADDR_W-1:0];

  fblm_state_t state_reg;
  logic tool_req_sync;
  logic tool_ctrl_reg;
  logic [fblm_pkg::ERR_W-1:0] err_total_reg;
  logic [fblm_pkg::RETRY_W-1:0] retry_limit_reg;
  logic [fblm_pkg::RETRY_W-1:0] retry_left_reg;
  logic [1:0] op_kind_reg;
  logic op_sweep_reg;
  logic [fblm_pkg::ADDR_W-1:0] op_addr_reg;
  logic [fblm_pkg::DATA_W-1:0] op_data_reg;
  logic [1:0] op_status_reg;
  logic [fblm_pkg::DATA_W-1:0] op_rdata_reg;
  logic [fblm_pkg::TYPE_W-1:0] slave_type_mem [NSLV+1];
  logic [fblm_pkg::DATA_W-1:0] init_mem [NSLV+1];
  logic err_indicator_reg;
  logic cmd_owner_ok;
  logic cmd_take;
  logic rsp_fail;
  logic retry_now;
  logic err_event;

  // tool control request comes from a pin
  fblm_sync2 #(.WIDTH(1)) u_tool_sync (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .d_in(tool_ctrl_req_in),
    .q_out(tool_req_sync)
  );

  // command acceptance and event decode
  assign cmd_owner_ok = (cmd_from_tool_in == tool_ctrl_reg); // RL15 RL21
  assign cmd_ready_out = (state_reg == FBLM_IDLE);
  assign cmd_take = cmd_valid_in && cmd_ready_out;
  assign rsp_fail = bus_rsp_valid_in && (bus_rsp_status_in == fblm_pkg::RSP_FAIL);
  assign retry_now = (state_reg == FBLM_WAIT) && rsp_fail && (retry_left_reg != '0); // RL6 RL7
  assign err_event = bus_err_in || retry_now; // RL2

  // control right handover only while no bus operation runs
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tool_ctrl_reg <= 1'b0;
    end else if (state_reg == FBLM_IDLE && !cmd_valid_in) begin
      tool_ctrl_reg <= tool_req_sync; // RL16
    end
  end
  assign tool_has_ctrl_out = tool_ctrl_reg;
  assign host_ready_indicator_out = !tool_ctrl_reg; // RL18

  // error indicator latches, survives control changes
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      err_indicator_reg <= 1'b0;
    end else if (err_event || hw_fault_in) begin
      err_indicator_reg <= 1'b1; // RL17
    end else if (cmd_take && cmd_owner_ok && cmd_code_in == fblm_pkg::FBLM_CMD_CLEAR_ERR) begin
      err_indicator_reg <= 1'b0;
    end
  end
  assign error_indicator_out = err_indicator_reg;

  // saturating error total; a new error wins over a clear
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      err_total_reg <= fblm_pkg::ERR_RESET; // RL20
    end else if (err_event) begin
      if (err_total_reg != fblm_pkg::ERR_MAX) begin
        err_total_reg <= err_total_reg + 16'h0001; // RL2 RL3
      end
    end else if (cmd_take && cmd_owner_ok && cmd_code_in == fblm_pkg::FBLM_CMD_CLEAR_ERR) begin
      err_total_reg <= fblm_pkg::ERR_RESET; // RL4
    end
  end

  // retry limit from environment-setup parameters
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      retry_limit_reg <= fblm_pkg::RETRY_RESET;
    end else if (cmd_take && cmd_owner_ok && cmd_code_in == fblm_pkg::FBLM_CMD_ENV_SET) begin
      retry_limit_reg <= cmd_data_in[fblm_pkg::RETRY_W-1:0]; // RL5 RL7
    end
  end

  // stored initial data, written only from the tool port
  always_ff @(posedge clock_in) begin
    if (cmd_take && cmd_owner_ok && cmd_from_tool_in
        && cmd_code_in == fblm_pkg::FBLM_CMD_WRITE_INIT) begin
      init_mem[cmd_addr_in] <= cmd_data_in; // RL13
    end
  end

  // slave type table filled by initialization replies
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i <= NSLV; i++) begin
        slave_type_mem[i] <= '0;
      end
    end else if (state_reg == FBLM_WAIT && bus_rsp_valid_in && op_kind_reg == fblm_pkg::REQ_INIT) begin
      slave_type_mem[op_addr_reg] <= (bus_rsp_status_in == fblm_pkg::RSP_OK)
                                     ? bus_rsp_type_in : '0; // RL1
    end
  end

  // operation sequencer
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= FBLM_IDLE;
      op_kind_reg <= fblm_pkg::REQ_USER;
      op_sweep_reg <= 1'b0;
      op_addr_reg <= '0;
      op_data_reg <= '0;
      op_status_reg <= fblm_pkg::ST_OK;
      op_rdata_reg <= '0;
      retry_left_reg <= '0;
    end else begin
      case (state_reg)
        FBLM_IDLE: begin
          op_status_reg <= fblm_pkg::ST_OK;
          op_rdata_reg <= '0;
          op_data_reg <= cmd_data_in;
          op_addr_reg <= cmd_addr_in;
          if (cmd_take) begin
            if (!cmd_owner_ok) begin
              op_status_reg <= fblm_pkg::ST_BUSY; // RL21
              state_reg <= FBLM_DONE;
            end else begin
              case (cmd_code_in)
                fblm_pkg::FBLM_CMD_ENV_SET: begin
                  op_kind_reg <= fblm_pkg::REQ_INIT; // RL8
                  op_sweep_reg <= 1'b1;
                  op_addr_reg <= 4'h1;
                  state_reg <= FBLM_SEND;
                end
                fblm_pkg::FBLM_CMD_SEND_INIT: begin
                  op_kind_reg <= fblm_pkg::REQ_INIT_DATA; // RL14
                  op_sweep_reg <= 1'b1;
                  op_addr_reg <= 4'h1;
                  state_reg <= FBLM_SEND;
                end
                fblm_pkg::FBLM_CMD_TRANSFER: begin
                  op_kind_reg <= fblm_pkg::REQ_USER;
                  op_sweep_reg <= 1'b0;
                  state_reg <= FBLM_SEND;
                end
                fblm_pkg::FBLM_CMD_READ_TYPE: begin
                  op_rdata_reg <= {8'h00, slave_type_mem[cmd_addr_in]}; // RL1
                  state_reg <= FBLM_DONE;
                end
                fblm_pkg::FBLM_CMD_READ_ERR: begin
                  op_rdata_reg <= err_total_reg;
                  state_reg <= FBLM_DONE;
                end
                default: begin
                  state_reg <= FBLM_DONE;
                end
              endcase
            end
          end
        end
        FBLM_SEND: begin
          retry_left_reg <= retry_limit_reg; // RL7
          if (op_kind_reg == fblm_pkg::REQ_INIT_DATA) begin
            op_data_reg <= init_mem[op_addr_reg]; // RL14
          end
          state_reg <= FBLM_WAIT;
        end
        FBLM_WAIT: begin
          if (retry_now) begin
            retry_left_reg <= retry_left_reg - 2'h1; // RL6
          end else if (bus_rsp_valid_in) begin
            op_rdata_reg <= bus_rsp_data_in;
            if (bus_rsp_status_in == fblm_pkg::RSP_INIT_ERR) begin
              op_status_reg <= fblm_pkg::ST_INIT_ERR; // RL10 RL11
            end else if (bus_rsp_status_in == fblm_pkg::RSP_FAIL) begin
              op_status_reg <= fblm_pkg::ST_BUS_ERR;
            end
            state_reg <= op_sweep_reg ? FBLM_NEXT : FBLM_DONE;
          end
        end
        FBLM_NEXT: begin
          if (op_addr_reg == LAST_ADDR) begin
            state_reg <= FBLM_DONE;
          end else begin
            op_addr_reg <= op_addr_reg + 4'h1; // RL8 RL14
            state_reg <= FBLM_SEND;
          end
        end
        FBLM_DONE: begin
          state_reg <= FBLM_IDLE;
        end
        default: begin
          state_reg <= FBLM_IDLE;
        end
      endcase
    end
  end

  // bus request held while waiting; a retry re-sends the same frame
  assign bus_req_valid_out = (state_reg == FBLM_WAIT) && (retry_now || !bus_rsp_valid_in);
  assign bus_req_kind_out = op_kind_reg;
  assign bus_req_src_out = fblm_pkg::MASTER_ADDR; // RL19
  assign bus_req_dst_out = op_addr_reg;
  assign bus_req_data_out = op_data_reg;

  // host answer
  assign rsp_valid_out = (state_reg == FBLM_DONE);
  assign rsp_status_out = op_status_reg;
  assign rsp_data_out = op_rdata_reg;
endmodule

// *** verilog/fblm_sync2.sv ***
// two-stage synchroniser for pin-level inputs
module fblm_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // data
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_reg;

  // first stage read only by second
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_reg <= '0;
      q_out <= '0;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule
